//--- rtl/ptm_pkg.sv
// shared constants of the period timer: register map, fields, modes, reset values
// assumes a single 10 MHz clock domain and a plain register port
package ptm_pkg;

    // ==========================================================
    // register port
    localparam int ADDR_W = 3;
    localparam int DATA_W = 16;

    localparam logic [ADDR_W-1:0] REG_CTRL = 3'h0;
    localparam logic [ADDR_W-1:0] REG_PERIOD = 3'h1;
    localparam logic [ADDR_W-1:0] REG_PULSE = 3'h2;
    localparam logic [ADDR_W-1:0] REG_COUNT = 3'h3;
    localparam logic [ADDR_W-1:0] REG_STATUS = 3'h4;
    localparam logic [ADDR_W-1:0] REG_IRQ_EN = 3'h5;

    // ==========================================================
    // control register fields
    localparam int CTRL_RUN_BIT = 15;
    localparam int CTRL_MODE_LSB = 8;
    localparam int MODE_W = 5;
    localparam int CTRL_PS_LSB = 0;
    localparam int PS_W = 4;

    // ==========================================================
    // status and enable fields
    localparam int STAT_W = 2;
    localparam int STAT_TIMER_IRQ = 0;
    localparam int STAT_ONESHOT_DONE = 1;

    // ==========================================================
    // modes
    localparam logic [MODE_W-1:0] MODE_FREE = 5'h00;
    localparam logic [MODE_W-1:0] MODE_OS_LOW = 5'h0e;
    localparam logic [MODE_W-1:0] MODE_OS_HIGH = 5'h0f;

    // ==========================================================
    // reset values and timing
    localparam logic [DATA_W-1:0] CTRL_RESET = 16'h0000;
    localparam logic [7:0] PERIOD_RESET = 8'hff;
    localparam logic [7:0] PULSE_RESET = 8'h00;
    localparam logic [STAT_W-1:0] MASK_RESET = 2'h0;
    localparam int SYNC_STAGES = 2;

endpackage : ptm_pkg

//--- rtl/ptm_postscaler.sv
// postscaler: counts period matches, pulses at the selected ratio,
// then delays the pulse through a short synchronising pipeline
// assumes match_in is a one-cycle pulse from the same clock
`timescale 1ns/1ps
`default_nettype none

module ptm_postscaler
    import ptm_pkg::*;
(
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire logic match_in,
    input wire logic [PS_W-1:0] select_in,
    output logic post_pulse_out,
    output logic flag_set_out
);

    logic [PS_W-1:0] post_cnt_r;
    logic [PS_W-1:0] post_cnt_nxt;
    logic post_pulse_r;
    logic post_pulse_nxt;
    logic [SYNC_STAGES-1:0] dly_r;
    logic [SYNC_STAGES-1:0] dly_nxt;

    // ==========================================================
    // ratio counter
    always_comb begin
        post_cnt_nxt = post_cnt_r;
        post_pulse_nxt = 1'b0;
        if (match_in) begin
            if (post_cnt_r >= select_in) begin
                post_cnt_nxt = '0;
                post_pulse_nxt = 1'b1;
            end else begin
                post_cnt_nxt = post_cnt_r + 4'h1;
            end
        end
        // pipeline starts beside the pulse register so the flag lands one clock after it
        dly_nxt = {dly_r[SYNC_STAGES-2:0], post_pulse_nxt};
    end

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            post_cnt_r <= '0;
            post_pulse_r <= 1'b0;
            dly_r <= '0;
        end else begin
            post_cnt_r <= post_cnt_nxt;
            post_pulse_r <= post_pulse_nxt;
            dly_r <= dly_nxt;
        end
    end

    assign post_pulse_out = post_pulse_r;
    assign flag_set_out = dly_r[SYNC_STAGES-1];

endmodule // ptm_postscaler

`default_nettype wire

//--- rtl/ptm_timer.sv
// period-match timer with postscaled interrupt and level-reset one-shot mode
// assumes one 10 MHz clock, synchronous reset and a plain register port;
// the external trigger arrives asynchronously
//
// Added by the designer: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - interrupt event when postscaler count reaches selected ratio, 1:1 to 1:16
// - timer interrupt reaches the output only while its enable bit is set
// - one-shot: count held clear at reset level, starts on edge while running
// - mode 01110 selects low reset level, 01111 selects high reset level
// - one-shot: count equal to period clears count and clears run bit
// - after run clears, a fresh edge after setting run is needed to restart
// - one-shot pwm drive goes active on the starting edge
// - pwm drive goes inactive when count equals pulse width value
// - period match never reactivates one-shot pwm drive
// - up to two cycles sync delay from postscaled match to flag
module ptm_timer
    import ptm_pkg::*;
#(
    parameter int CNT_W = 8
) (
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [DATA_W-1:0] wr_data_in,
    input wire logic wr_en_in,
    input wire logic rd_en_in,
    input wire logic ext_trig_in,
    output logic [DATA_W-1:0] rd_data_out,
    output logic irq_out,
    output logic pwm_out,
    output logic postscaled_match_out
);

    // ==========================================================
    // declarations
    logic trig_meta_r;
    logic trig_sync_r;
    logic trig_prev_r;

    logic run_r;
    logic run_nxt;
    logic [MODE_W-1:0] mode_r;
    logic [MODE_W-1:0] mode_nxt;
    logic [PS_W-1:0] postscale_select_r;
    logic [PS_W-1:0] postscale_select_nxt;
    logic [CNT_W-1:0] period_value_r;
    logic [CNT_W-1:0] period_value_nxt;
    logic [CNT_W-1:0] pulse_width_value_r;
    logic [CNT_W-1:0] pulse_width_value_nxt;

    logic [CNT_W-1:0] count_r;
    logic [CNT_W-1:0] count_nxt;
    logic started_r;
    logic started_nxt;
    logic pwm_r;
    logic pwm_nxt;
    logic run_hw_clear;
    logic period_match;

    logic [STAT_W-1:0] status_r;
    logic [STAT_W-1:0] status_nxt;
    logic [STAT_W-1:0] periph_irq_enable_r;
    logic [STAT_W-1:0] periph_irq_enable_nxt;
    logic irq_r;
    logic irq_nxt;
    logic [DATA_W-1:0] rd_data_r;
    logic [DATA_W-1:0] rd_data_nxt;

    logic is_oneshot;
    logic reset_level;
    logic trig_at_reset;
    logic start_edge;
    logic post_pulse;
    logic flag_set;

    // ==========================================================
    // trigger synchroniser and edge history
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            trig_meta_r <= 1'b0;
            trig_sync_r <= 1'b0;
            trig_prev_r <= 1'b0;
        end else begin
            trig_meta_r <= ext_trig_in;
            trig_sync_r <= trig_meta_r;
            trig_prev_r <= trig_sync_r;
        end
    end

    // ==========================================================
    // mode decode
    always_comb begin
        is_oneshot = (mode_r == MODE_OS_LOW) || (mode_r == MODE_OS_HIGH);
        reset_level = (mode_r == MODE_OS_HIGH);
        trig_at_reset = (trig_sync_r == reset_level);
        start_edge = (trig_prev_r == reset_level) && (trig_sync_r != reset_level);
        period_match = run_r && (count_r == period_value_r) && (!is_oneshot || started_r);
    end

    // ==========================================================
    // counter and pwm drive
    always_comb begin
        count_nxt = count_r;
        started_nxt = started_r;
        pwm_nxt = pwm_r;
        run_hw_clear = 1'b0;
        if (is_oneshot) begin
            if (!run_r || trig_at_reset) begin
                count_nxt = '0;
                started_nxt = 1'b0;
                pwm_nxt = 1'b0;
            end else if (!started_r) begin
                if (start_edge) begin
                    started_nxt = 1'b1;
                    count_nxt = '0;
                    pwm_nxt = (pulse_width_value_r != '0);
                end
            end else if (period_match) begin
                count_nxt = '0;
                started_nxt = 1'b0;
                run_hw_clear = 1'b1;
                pwm_nxt = 1'b0;
            end else begin
                count_nxt = count_r + 1'b1;
                if (count_r + 1'b1 == pulse_width_value_r) begin
                    pwm_nxt = 1'b0;
                end
            end
        end else begin
            started_nxt = 1'b0;
            if (!run_r) begin
                pwm_nxt = 1'b0;
            end else if (period_match) begin
                count_nxt = '0;
                pwm_nxt = (pulse_width_value_r != '0);
            end else begin
                count_nxt = count_r + 1'b1;
                if (count_r + 1'b1 == pulse_width_value_r) begin
                    pwm_nxt = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            count_r <= '0;
            started_r <= 1'b0;
            pwm_r <= 1'b0;
        end else begin
            count_r <= count_nxt;
            started_r <= started_nxt;
            pwm_r <= pwm_nxt;
        end
    end

    // ==========================================================
    // postscaler and sync delay
    ptm_postscaler u_postscaler (
        .mclk_in(mclk_in),
        .reset_in(reset_in),
        .match_in(period_match),
        .select_in(postscale_select_r),
        .post_pulse_out(post_pulse),
        .flag_set_out(flag_set)
    );

    // ==========================================================
    // control registers
    always_comb begin
        run_nxt = run_r;
        mode_nxt = mode_r;
        postscale_select_nxt = postscale_select_r;
        period_value_nxt = period_value_r;
        pulse_width_value_nxt = pulse_width_value_r;
        periph_irq_enable_nxt = periph_irq_enable_r;
        if (run_hw_clear) begin
            run_nxt = 1'b0;
        end
        if (wr_en_in) begin
            unique case (addr_in)
                REG_CTRL: begin
                    run_nxt = wr_data_in[CTRL_RUN_BIT];
                    mode_nxt = wr_data_in[CTRL_MODE_LSB +: MODE_W];
                    postscale_select_nxt = wr_data_in[CTRL_PS_LSB +: PS_W];
                end
                REG_PERIOD: period_value_nxt = wr_data_in[CNT_W-1:0];
                REG_PULSE: pulse_width_value_nxt = wr_data_in[CNT_W-1:0];
                REG_IRQ_EN: periph_irq_enable_nxt = wr_data_in[STAT_W-1:0];
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            run_r <= CTRL_RESET[CTRL_RUN_BIT];
            mode_r <= CTRL_RESET[CTRL_MODE_LSB +: MODE_W];
            postscale_select_r <= CTRL_RESET[CTRL_PS_LSB +: PS_W];
            period_value_r <= PERIOD_RESET[CNT_W-1:0];
            pulse_width_value_r <= PULSE_RESET[CNT_W-1:0];
            periph_irq_enable_r <= MASK_RESET;
        end else begin
            run_r <= run_nxt;
            mode_r <= mode_nxt;
            postscale_select_r <= postscale_select_nxt;
            period_value_r <= period_value_nxt;
            pulse_width_value_r <= pulse_width_value_nxt;
            periph_irq_enable_r <= periph_irq_enable_nxt;
        end
    end

    // ==========================================================
    // status, interrupt and read data
    always_comb begin
        status_nxt = status_r;
        if (rd_en_in && addr_in == REG_STATUS) begin
            status_nxt = '0;
        end
        // a set in the clearing cycle wins
        if (flag_set) begin
            status_nxt[STAT_TIMER_IRQ] = 1'b1;
        end
        if (run_hw_clear) begin
            status_nxt[STAT_ONESHOT_DONE] = 1'b1;
        end
        irq_nxt = |(status_nxt & periph_irq_enable_nxt);

        rd_data_nxt = '0;
        if (rd_en_in) begin
            unique case (addr_in)
                REG_CTRL: begin
                    rd_data_nxt[CTRL_RUN_BIT] = run_r;
                    rd_data_nxt[CTRL_MODE_LSB +: MODE_W] = mode_r;
                    rd_data_nxt[CTRL_PS_LSB +: PS_W] = postscale_select_r;
                end
                REG_PERIOD: rd_data_nxt[CNT_W-1:0] = period_value_r;
                REG_PULSE: rd_data_nxt[CNT_W-1:0] = pulse_width_value_r;
                REG_COUNT: rd_data_nxt[CNT_W-1:0] = count_r;
                REG_STATUS: rd_data_nxt[STAT_W-1:0] = status_r;
                REG_IRQ_EN: rd_data_nxt[STAT_W-1:0] = periph_irq_enable_r;
                default: rd_data_nxt = '0;
            endcase
        end
    end

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            status_r <= '0;
            irq_r <= 1'b0;
            rd_data_r <= '0;
        end else begin
            status_r <= status_nxt;
            irq_r <= irq_nxt;
            rd_data_r <= rd_data_nxt;
        end
    end

    // ==========================================================
    // outputs
    assign rd_data_out = rd_data_r;
    assign irq_out = irq_r;
    assign pwm_out = pwm_r;
    assign postscaled_match_out = post_pulse;

endmodule // ptm_timer

`default_nettype wire

//--- test/ptm_trig_src.sv
// trigger source and pwm width meter on the timer's far side
// assumes the bench calls drive() from its main sequence
`timescale 1ns/1ps
`default_nettype none
module ptm_trig_src (
    input wire logic mclk_in,
    input wire logic pwm_in,
    output logic trig_out,
    output logic [7:0] width_out
);
    logic [7:0] hi_r = 8'h00;
    initial trig_out = 1'b0;
    initial width_out = 8'h00;
    // width of the last pwm pulse in clocks
    always @(posedge mclk_in) begin
        hi_r <= pwm_in ? hi_r + 8'h01 : 8'h00;
        if (!pwm_in && hi_r != 8'h00)
            width_out <= hi_r;
    end
    task automatic drive(input logic lvl);
        @(posedge mclk_in);
        trig_out <= lvl;
    endtask
endmodule // ptm_trig_src
`default_nettype wire

//--- test/ptm_timer_props.sv
// port checker of the period timer, bound into ptm_timer
// assumes ptm_pkg and a single clock domain
`timescale 1ns/1ps
`default_nettype none
module ptm_timer_props
    import ptm_pkg::*;
#(
    parameter int CNT_W = 8
) (
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [DATA_W-1:0] wr_data_in,
    input wire logic wr_en_in,
    input wire logic rd_en_in,
    input wire logic ext_trig_in,
    input wire logic [DATA_W-1:0] rd_data_out,
    input wire logic irq_out,
    input wire logic pwm_out,
    input wire logic postscaled_match_out
);
    // ========
    // shadow of run, mode, enables; cycles at reset level
    logic [MODE_W:0] ctl_r, ctl_nxt;
    logic [STAT_W-1:0] en_r, en_nxt;
    logic [2:0] lvl_r, lvl_nxt;
    logic os, act, run, st_rd;
    always_comb begin
        os = ctl_r[MODE_W-1:1] == 4'h7;
        act = ext_trig_in ^ ctl_r[0];
        run = ctl_r[MODE_W];
        st_rd = rd_en_in && addr_in == REG_STATUS;
        ctl_nxt = ctl_r;
        en_nxt = en_r;
        lvl_nxt = (!os || act) ? 3'h0 : lvl_r + {2'h0, lvl_r != 3'h7};
        if (wr_en_in && addr_in == REG_CTRL)
            ctl_nxt = {wr_data_in[CTRL_RUN_BIT], wr_data_in[CTRL_MODE_LSB +: MODE_W]};
        if (wr_en_in && addr_in == REG_IRQ_EN)
            en_nxt = wr_data_in[STAT_W-1:0];
    end
    always_ff @(posedge mclk_in) begin
        ctl_r <= reset_in ? '0 : ctl_nxt;
        en_r <= reset_in ? '0 : en_nxt;
        lvl_r <= reset_in ? 3'h0 : lvl_nxt;
    end
    default clocking @(posedge mclk_in); endclocking
    default disable iff (reset_in);
    // ========
    // assertions
    a_read_idle_zero: assert property (!$past(rd_en_in) |-> rd_data_out == '0)
        else $error("read data outside read cycle");
    a_irq_masked: assert property (en_r == '0 && $past(en_r) == '0 |-> !irq_out)
        else $error("irq with enables clear");
    a_irq_sync_delay: assert property (
        postscaled_match_out && en_r[0] |-> ##2 (irq_out || !en_r[0]))
        else $error("irq late after match");
    a_irq_sticky_flag: assert property (
        $fell(irq_out) |-> $past(st_rd) || $past(st_rd, 2) || $past(wr_en_in) || $past(wr_en_in, 2))
        else $error("irq dropped unread");
    a_match_needs_run: assert property (
        postscaled_match_out |-> $past(run) || $past(run, 2) || $past(run, 3))
        else $error("match while stopped");
    a_pwm_held_low: assert property (os && lvl_r > 3'h4 |-> !pwm_out)
        else $error("pwm at reset level");
    a_pwm_start_edge: assert property ($rose(pwm_out) && os |-> $past(act, 2))
        else $error("pwm start without edge");
    a_pwm_no_rearm: assert property ($fell(pwm_out) && os |=> !pwm_out [*4])
        else $error("pwm rearmed");
    c_irq_rise: cover property ($rose(irq_out));
    c_os_pwm: cover property ($rose(pwm_out) && os);
    c_ps_pulse: cover property (postscaled_match_out ##1 !postscaled_match_out);
endmodule // ptm_timer_props
bind ptm_timer ptm_timer_props #(.CNT_W(CNT_W)) u_props (.mclk_in, .reset_in, .addr_in,
    .wr_data_in, .wr_en_in, .rd_en_in, .ext_trig_in, .rd_data_out, .irq_out, .pwm_out,
    .postscaled_match_out);
`default_nettype wire

//--- test/ptm_timer_tb_top.sv
// self-checking bench of the period timer
// assumes the trigger source model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module ptm_timer_tb_top
    import ptm_pkg::*;
;
    logic mclk_in = 1'b0;
    logic reset_in = 1'b1;
    logic [ADDR_W-1:0] addr_in = '0;
    logic [DATA_W-1:0] wr_data_in = '0;
    logic wr_en_in = 1'b0;
    logic rd_en_in = 1'b0;
    logic ext_trig_in;
    logic [DATA_W-1:0] rd_data_out;
    logic irq_out, pwm_out, postscaled_match_out;
    logic [7:0] pw;
    logic [MODE_W-1:0] m;
    int failures = 0;
    int check_count = 0;
    int cyc = 0;
    int n;
    always #50 mclk_in = ~mclk_in;
    ptm_timer #(.CNT_W(8)) DUT (.mclk_in, .reset_in, .addr_in, .wr_data_in, .wr_en_in,
        .rd_en_in, .ext_trig_in, .rd_data_out, .irq_out, .pwm_out, .postscaled_match_out);
    ptm_trig_src TRG (.mclk_in, .pwm_in(pwm_out), .trig_out(ext_trig_in), .width_out(pw));
    // ========
    // access and compare tasks
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_bit(input string nm, input logic e, input logic g);
        chk(nm, {15'h0, e}, {15'h0, g});
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
        @(posedge mclk_in);
        wr_en_in <= 1'b1;
        addr_in <= a;
        wr_data_in <= d;
        @(posedge mclk_in);
        wr_en_in <= 1'b0;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [15:0] e);
        @(posedge mclk_in);
        rd_en_in <= 1'b1;
        addr_in <= a;
        @(posedge mclk_in);
        rd_en_in <= 1'b0;
        #1 chk("read", e, rd_data_out);
    endtask
    task automatic idle(input int k);
        repeat (k) @(posedge mclk_in);
        #1;
    endtask
    // bounded wait: 0 match pulse, 1 irq, 2 pwm; n holds cycles
    task automatic wait_for(input int s, input logic v);
        n = 0;
        do begin
            @(posedge mclk_in);
            #1 n++;
        end while ((s == 0 ? postscaled_match_out : s == 1 ? irq_out : pwm_out) !== v
            && n < 400);
        chk_bit("wait", 1'b0, n >= 400);
    endtask
    task automatic stop_test();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge mclk_in) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            stop_test();
        end
    end
    // ========
    // main sequence
    initial begin
        repeat (10) @(posedge mclk_in);
        reset_in <= 1'b0;
        for (int a = 0; a < 8; a++)
            rd(3'(a), a == 1 ? 16'h00ff : 16'h0000);
        wr(REG_COUNT, 16'h00aa);
        rd(REG_COUNT, 16'h0000);
        wr(REG_PERIOD, 16'h0003);
        for (int s = 0; s < 16; s++) begin
            wr(REG_CTRL, {12'h800, 4'(s)});
            wait_for(0, 1'b1);
            wait_for(0, 1'b1);
            chk("spacing", 16'(4 * (s + 1)), 16'(n));
        end
        chk_bit("irq masked", 1'b0, irq_out);
        wait_for(0, 1'b1);
        wr(REG_CTRL, 16'h0000);
        idle(3);
        rd(REG_STATUS, 16'h0001);
        rd(REG_STATUS, 16'h0000);
        wr(REG_IRQ_EN, 16'h0001);
        wr(REG_CTRL, 16'h8000);
        wait_for(1, 1'b1);
        wr(REG_CTRL, 16'h0000);
        idle(6);
        chk_bit("irq held", 1'b1, irq_out);
        rd(REG_STATUS, 16'h0001);
        idle(3);
        chk_bit("irq clear", 1'b0, irq_out);
        wr(REG_PULSE, 16'h0002);
        wr(REG_PERIOD, 16'h0005);
        for (int i = 0; i < 2; i++) begin
            m = i ? MODE_OS_HIGH : MODE_OS_LOW;
            TRG.drive(m[0]);
            wr(REG_CTRL, {3'h4, m, 8'h00});
            idle(8);
            chk_bit("pwm", 1'b0, pwm_out);
            rd(REG_COUNT, 16'h0000);
            TRG.drive(!m[0]);
            wait_for(2, 1'b1);
            wait_for(2, 1'b0);
            idle(10);
            chk("width", 16'h0002, {8'h00, pw});
            chk_bit("pwm", 1'b0, pwm_out);
            rd(REG_CTRL, {3'h0, m, 8'h00});
            rd(REG_STATUS, 16'h0003);
            TRG.drive(m[0]);
            idle(4);
            TRG.drive(!m[0]);
            idle(8);
            chk_bit("pwm", 1'b0, pwm_out);
            wr(REG_CTRL, {3'h4, m, 8'h00});
            idle(8);
            chk_bit("pwm", 1'b0, pwm_out);
            TRG.drive(m[0]);
            idle(4);
            TRG.drive(!m[0]);
            wait_for(2, 1'b1);
            wait_for(2, 1'b0);
            idle(10);
            rd(REG_STATUS, 16'h0003);
            TRG.drive(m[0]);
        end
        stop_test();
    end
endmodule // ptm_timer_tb_top
`default_nettype wire
